// >>> emif_pkg.sv
// Purpose: Shared constants and carrier types for the external data memory interface
// Assumes: One system clock; configuration arrives as plain ports
// Notes: Field positions follow the configuration and timing bytes
package emif_pkg;

  // Configuration byte fields
  localparam int EMIF_CFG_MUX_BIT = 4;
  localparam int EMIF_CFG_MODE_HI = 3;
  localparam int EMIF_CFG_MODE_LO = 2;
  localparam int EMIF_CFG_ALE_HI = 1;
  localparam int EMIF_CFG_ALE_LO = 0;
  // Timing byte fields
  localparam int EMIF_TC_SETUP_HI = 7;
  localparam int EMIF_TC_SETUP_LO = 6;
  localparam int EMIF_TC_STRB_HI = 5;
  localparam int EMIF_TC_STRB_LO = 2;
  localparam int EMIF_TC_HOLD_HI = 1;
  localparam int EMIF_TC_HOLD_LO = 0;
  // Values after reset
  localparam logic [7:0] EMIF_TC_RESET = 8'hff;
  localparam logic [7:0] EMIF_CFG_RESET = 8'h00;
  // Fixed overhead of an off-chip access in system clocks
  localparam logic [5:0] EMIF_FIXED_OVERHEAD = 6'h04;
  // Size of on-chip data memory: 8 kB
  localparam logic [15:0] EMIF_INT_SIZE = 16'h2000;
  localparam logic [15:0] EMIF_INT_MASK = 16'h1fff;

  // Address-map modes
  typedef enum logic [1:0] {
    EMIF_MODE_INT_ONLY = 2'b00,
    EMIF_MODE_SPLIT_NOBANK = 2'b01,
    EMIF_MODE_SPLIT_BANK = 2'b10,
    EMIF_MODE_EXT_ONLY = 2'b11
  } emif_mode_e;

  // One access request from the processor
  typedef struct packed {
    logic is_write;
    logic wide;
    logic use_idx_one;
    logic [7:0] wdata;
  } emif_req_s;

  // Programmed timing in system clocks
  typedef struct packed {
    logic [1:0] setup;
    logic [3:0] strobe;
    logic [1:0] hold;
    logic [1:0] ale;
  } emif_timing_s;

endpackage

// >>> emif_route.sv
// Purpose: Effective address and on-chip or off-chip routing decision
// Assumes: Pure combinational decode
// Notes: Upper address drive flag tells the pin logic whether A[15:8] is driven
`timescale 1ns/1ps
module emif_route
  import emif_pkg::*;
(
  // Mode and request
  input wire emif_mode_e i_mode,
  input wire logic i_wide,
  input wire logic i_use_idx_one,
  // Address sources
  input wire logic [7:0] i_page,
  input wire logic [7:0] i_idx_zero,
  input wire logic [7:0] i_idx_one,
  input wire logic [15:0] i_data_pointer,
  // Decision
  output logic [15:0] o_addr,
  output logic o_offchip,
  output logic o_drive_high
);

  // Chosen index register
  wire [7:0] idx_sel = i_use_idx_one ? i_idx_one : i_idx_zero;
  // Full address as seen by the processor
  wire [15:0] raw_addr = i_wide ? i_data_pointer : {i_page, idx_sel};
  // page decides split: high byte comes from page for narrow access
  wire above_int = (raw_addr >= EMIF_INT_SIZE);

  // Routing by mode
  always_comb begin
    o_addr = raw_addr;
    o_offchip = 1'b0;
    o_drive_high = 1'b0;
    unique case (i_mode)
      EMIF_MODE_INT_ONLY: begin
        o_addr = raw_addr & EMIF_INT_MASK;
        o_offchip = 1'b0;
      end
      EMIF_MODE_SPLIT_NOBANK: begin
        o_offchip = above_int;
        o_drive_high = i_wide;
      end
      EMIF_MODE_SPLIT_BANK: begin
        o_offchip = above_int;
        o_drive_high = 1'b1;
      end
      EMIF_MODE_EXT_ONLY: begin
        o_offchip = 1'b1;
        o_drive_high = i_wide;
      end
    endcase
  end

endmodule

// >>> emif_top.sv
// Purpose: External data memory interface: routing, pin sequencing and timing
// Assumes: Inputs synchronous to i_clk_sys; one request at a time
// Notes: On-chip accesses are handed to o_int_* and finish in one cycle
//
// Behaviour
// - Pin arrangement follows bus mux select
// - Muxed: data and low address share pins
// - Muxed: device drives address latch strobe
// - First muxed phase: strobe high, low address
// - After strobe low phase ends, shared pins carry data
// - Non-muxed: separate address and data pins
// - Mode 00: all internal, alias 8 kB
// - Internal 8-bit: page high, index low
// - Internal 16-bit: data pointer address
// - Mode 01: split at internal boundary
// - Split no bank: 8-bit leaves high undriven
// - Split 8-bit routing uses page register
// - Split 16-bit: data pointer, all pins
// - Mode 10: 8-bit high byte from page
// - Mode 11: everything off-chip
// - External 8-bit: ignore page, high undriven
// - External 16-bit: data pointer, all pins
// - Setup, hold, strobe, latch widths programmable
// - Off-chip access: parameters plus four clocks
// - Muxed adds latch strobe, minimum seven
// - Setup and hold reset to maximum
// - Latch high and low width field plus one
// - Setup equals field value
// - Strobe width field plus one
// - Hold equals field value
`timescale 1ns/1ps
module emif_top
  import emif_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Configuration
  input wire logic i_cfg_we,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic i_tc_we,
  input wire logic [7:0] i_tc_wdata,
  input wire logic [7:0] i_page,
  // Address sources
  input wire logic [7:0] i_idx_zero,
  input wire logic [7:0] i_idx_one,
  input wire logic [15:0] i_data_pointer,
  // Processor request
  input wire logic i_req,
  input wire emif_req_s i_req_info,
  // Processor answer
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  // On-chip memory port
  output logic o_int_en,
  output logic o_int_we,
  output logic [12:0] o_int_addr,
  output logic [7:0] o_int_wdata,
  input wire logic [7:0] i_int_rdata,
  // Configuration readback
  output logic [7:0] o_cfg,
  output logic [7:0] o_tc,
  // External pins
  output logic o_ale,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [7:0] o_addr_hi,
  output logic o_addr_hi_oe,
  output logic [7:0] o_addr_lo,
  output logic o_addr_lo_oe,
  output logic [7:0] o_data_out,
  output logic o_data_oe,
  input wire logic [7:0] i_data_in
);

  // Sequencer states
  typedef enum logic [2:0] {
    EMIF_ST_IDLE = 3'b000,
    EMIF_ST_ALE_HI = 3'b001,
    EMIF_ST_ALE_LO = 3'b010,
    EMIF_ST_SETUP = 3'b011,
    EMIF_ST_STROBE = 3'b100,
    EMIF_ST_HOLD = 3'b101,
    EMIF_ST_END = 3'b110
  } emif_state_e;

  // Registers
  logic [7:0] cfg_reg; // Configuration byte
  logic [7:0] tc_reg; // Timing byte
  emif_state_e state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next; // Phase countdown
  logic [15:0] addr_reg; // Latched effective address
  logic hi_reg; // Drive upper address pins
  emif_req_s req_reg; // Latched request
  logic [1:0] ovh_reg, ovh_next; // Fixed overhead countdown

  // Decoded configuration
  // mux select decode
  wire mux_mode = ~cfg_reg[EMIF_CFG_MUX_BIT];
  wire emif_mode_e mode = emif_mode_e'(cfg_reg[EMIF_CFG_MODE_HI:EMIF_CFG_MODE_LO]);
  wire emif_timing_s tim = '{setup: tc_reg[EMIF_TC_SETUP_HI:EMIF_TC_SETUP_LO],
                             strobe: tc_reg[EMIF_TC_STRB_HI:EMIF_TC_STRB_LO],
                             hold: tc_reg[EMIF_TC_HOLD_HI:EMIF_TC_HOLD_LO],
                             ale: cfg_reg[EMIF_CFG_ALE_HI:EMIF_CFG_ALE_LO]};

  // Route decode
  wire [15:0] r_addr;
  wire r_off;
  wire r_hi;
  emif_route u_route (
    .i_mode(mode),
    .i_wide(i_req_info.wide),
    .i_use_idx_one(i_req_info.use_idx_one),
    .i_page(i_page),
    .i_idx_zero(i_idx_zero),
    .i_idx_one(i_idx_one),
    .i_data_pointer(i_data_pointer),
    .o_addr(r_addr),
    .o_offchip(r_off),
    .o_drive_high(r_hi)
  );

  // Request acceptance
  wire idle = (state_reg == EMIF_ST_IDLE);
  wire take = i_req & idle;
  wire take_int = take & ~r_off;
  wire take_ext = take & r_off;
  wire cnt_zero = (cnt_reg == 4'h0);
  wire ovh_zero = (ovh_reg == 2'h0);
  // Overhead: four clocks = first setup cycle + END + two hold-tail cycles
  localparam logic [1:0] OVH_LOAD = 2'(EMIF_FIXED_OVERHEAD - 6'h03);

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ovh_next = ovh_reg;
    unique case (state_reg)
      EMIF_ST_IDLE: begin
        if (take_ext && mux_mode) begin
          state_next = EMIF_ST_ALE_HI;
          cnt_next = {2'b00, tim.ale};
        end else if (take_ext) begin
          state_next = EMIF_ST_SETUP;
          cnt_next = {2'b00, tim.setup};
        end
        ovh_next = OVH_LOAD;
      end
      EMIF_ST_ALE_HI: begin
        if (cnt_zero) begin
          state_next = EMIF_ST_ALE_LO;
          cnt_next = {2'b00, tim.ale};
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      EMIF_ST_ALE_LO: begin
        if (cnt_zero) begin
          state_next = EMIF_ST_SETUP;
          cnt_next = {2'b00, tim.setup};
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      EMIF_ST_SETUP: begin
        if (cnt_zero) begin
          state_next = EMIF_ST_STROBE;
          cnt_next = tim.strobe;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      EMIF_ST_STROBE: begin
        if (cnt_zero) begin
          state_next = EMIF_ST_HOLD;
          cnt_next = {2'b00, tim.hold};
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      EMIF_ST_HOLD: begin
        if (cnt_zero && ovh_zero) begin
          state_next = EMIF_ST_END;
        end else if (cnt_zero) begin
          ovh_next = ovh_reg - 2'h1;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      EMIF_ST_END: begin
        state_next = EMIF_ST_IDLE;
      end
      default: begin
        state_next = EMIF_ST_IDLE;
      end
    endcase
  end

  // Configuration registers
  // setup and hold reset max
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_reg <= EMIF_CFG_RESET;
      tc_reg <= EMIF_TC_RESET;
    end else begin
      if (i_cfg_we) begin
        cfg_reg <= {3'b000, i_cfg_wdata[4:0]};
      end
      if (i_tc_we) begin
        tc_reg <= i_tc_wdata;
      end
    end
  end

  // Sequencer state and captured request
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= EMIF_ST_IDLE;
      cnt_reg <= 4'h0;
      ovh_reg <= 2'h0;
      addr_reg <= 16'h0000;
      hi_reg <= 1'b0;
      req_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ovh_reg <= ovh_next;
      if (take_ext) begin
        addr_reg <= r_addr;
        hi_reg <= r_hi;
        req_reg <= i_req_info;
      end
    end
  end

  // Pin level decode for the next cycle
  wire in_ext = (state_next != EMIF_ST_IDLE);
  wire ale_next = (state_next == EMIF_ST_ALE_HI);
  wire strb_next = (state_next == EMIF_ST_STROBE);
  wire addr_phase = (state_next == EMIF_ST_ALE_HI) | (state_next == EMIF_ST_ALE_LO);
  wire [15:0] pin_addr = take_ext ? r_addr : addr_reg;
  wire pin_hi = take_ext ? r_hi : hi_reg;
  wire pin_wr = take_ext ? i_req_info.is_write : req_reg.is_write;
  wire [7:0] pin_wd = take_ext ? i_req_info.wdata : req_reg.wdata;

  // External pins; strobes inactive and enables cleared while idle or serving on-chip
  // on-chip leaves pins
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ale <= 1'b0;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_addr_hi <= 8'h00;
      o_addr_hi_oe <= 1'b0;
      o_addr_lo <= 8'h00;
      o_addr_lo_oe <= 1'b0;
      o_data_out <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_ale <= ale_next & mux_mode;
      o_rd_n <= ~(strb_next & ~pin_wr);
      o_wr_n <= ~(strb_next & pin_wr);
      if (in_ext) begin
        o_addr_hi <= pin_addr[15:8];
        o_addr_hi_oe <= pin_hi;
      end else begin
        o_addr_hi_oe <= 1'b0;
      end
      if (in_ext && mux_mode) begin
        o_addr_lo_oe <= 1'b0;
        o_data_out <= addr_phase ? pin_addr[7:0] : pin_wd;
        o_data_oe <= addr_phase | pin_wr;
      end else if (in_ext) begin
        o_addr_lo <= pin_addr[7:0];
        o_addr_lo_oe <= 1'b1;
        o_data_out <= pin_wd;
        o_data_oe <= pin_wr;
      end else begin
        o_addr_lo_oe <= 1'b0;
        o_data_oe <= 1'b0;
      end
    end
  end

  // Processor answer and on-chip port
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 8'h00;
      o_int_en <= 1'b0;
      o_int_we <= 1'b0;
      o_int_addr <= 13'h0000;
      o_int_wdata <= 8'h00;
      o_cfg <= EMIF_CFG_RESET;
      o_tc <= EMIF_TC_RESET;
    end else begin
      o_busy <= in_ext;
      o_int_en <= take_int;
      o_int_we <= take_int & i_req_info.is_write;
      if (take_int) begin
        o_int_addr <= r_addr[12:0];
        o_int_wdata <= i_req_info.wdata;
      end
      // On-chip answer one cycle after the enable; off-chip one cycle after END
      o_done <= o_int_en | (state_reg == EMIF_ST_END);
      if (o_int_en && !o_int_we) begin
        o_rdata <= i_int_rdata;
      end else if (state_reg == EMIF_ST_STROBE && cnt_zero && !req_reg.is_write) begin
        // Sample read data as the strobe ends
        o_rdata <= i_data_in;
      end
      o_cfg <= cfg_reg;
      o_tc <= tc_reg;
    end
  end

endmodule

// >>> emif_chk.sv
// Purpose: Pin and timing checks on the external memory interface
// Assumes: Sees only the top module's ports
// Notes: Bound to every emif_top instance
`timescale 1ns/1ps
module emif_chk
  import emif_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Watched outputs
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_int_en,
  input wire logic [7:0] o_cfg,
  input wire logic [7:0] o_tc,
  input wire logic o_ale,
  input wire logic o_rd_n,
  input wire logic o_wr_n,
  input wire logic o_data_oe
);
  // Cycles the read or write strobe has been low so far
  logic [4:0] strb_cnt_reg;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Count strobe-low cycles, clear between strobes
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strb_cnt_reg <= 5'h00;
    end else if (!o_rd_n || !o_wr_n) begin
      strb_cnt_reg <= strb_cnt_reg + 5'h01;
    end else begin
      strb_cnt_reg <= 5'h00;
    end
  end
  // Latch strobe sequence at the widest setting
  sequence ale_four_s;
    o_ale [*4] ##1 !o_ale;
  endsequence
  strobe_excl_a: assert property (o_rd_n || o_wr_n)
    else $error("read and write strobes low together");
  wr_data_a: assert property (!o_wr_n |-> o_data_oe)
    else $error("write strobe without data drive");
  ale_mux_a: assert property (o_ale |-> !o_cfg[EMIF_CFG_MUX_BIT])
    else $error("latch strobe outside multiplexed arrangement");
  ale_addr_a: assert property (o_ale |-> o_data_oe && o_rd_n && o_wr_n)
    else $error("address phase without address drive");
  ale_min_a: assert property ($rose(o_ale) && o_cfg[1:0] == 2'b00 |=> !o_ale)
    else $error("latch strobe high longer than one cycle");
  ale_max_a: assert property ($rose(o_ale) && o_cfg[1:0] == 2'b11 |-> ale_four_s)
    else $error("latch strobe high width not four cycles");
  strobe_width_a: assert property (o_rd_n && o_wr_n && strb_cnt_reg != 5'h00 |->
    strb_cnt_reg == {1'b0, o_tc[5:2]} + 5'h01)
    else $error("strobe width differs from field plus one");
  int_quiet_a: assert property (o_int_en |-> o_rd_n && o_wr_n && !o_ale)
    else $error("external strobe during on-chip access");
  busy_span_a: assert property (!o_rd_n || !o_wr_n || o_ale |-> o_busy)
    else $error("external strobe outside busy");
  tc_reset_a: assert property ($rose(i_rst_n) |-> o_tc == EMIF_TC_RESET)
    else $error("timing byte not at maximum after reset");
  done_end_a: assert property ($fell(o_busy) |-> o_done)
    else $error("off-chip access ended without done pulse");
  int_done_a: assert property (o_int_en |=> o_done)
    else $error("on-chip access without done pulse");
endmodule
bind emif_top emif_chk emif_chk_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .o_busy(o_busy),
  .o_done(o_done), .o_int_en(o_int_en), .o_cfg(o_cfg), .o_tc(o_tc), .o_ale(o_ale),
  .o_rd_n(o_rd_n), .o_wr_n(o_wr_n), .o_data_oe(o_data_oe));

// >>> emif_sram_model.sv
// Purpose: External byte memory with transparent address latch
// Assumes: Indexed by the low address byte only
// Notes: Released data lines show the inverse of the last read value
`timescale 1ns/1ps
module emif_sram_model (
  // Clock and arrangement
  input wire logic i_clk_sys,
  input wire logic i_mux,
  // Device pins
  input wire logic i_ale,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_addr_lo,
  input wire logic [7:0] i_data_out,
  // Answer and latch state
  output logic [7:0] o_data_in,
  output logic [7:0] o_lat
);
  logic [7:0] mem [256]; // Storage
  logic [7:0] last_reg = 8'h00; // Last value read
  logic [7:0] addr; // Selected address
  always_latch begin
    if (i_ale) begin
      o_lat = i_data_out;
    end
  end
  assign addr = i_mux ? o_lat : i_addr_lo;
  assign o_data_in = !i_rd_n ? mem[addr] : ~last_reg;
  // Store writes, remember reads
  always @(posedge i_clk_sys) begin
    if (!i_wr_n) begin
      mem[addr] <= i_data_out;
    end
    if (!i_rd_n) begin
      last_reg <= mem[addr];
    end
  end
endmodule

// >>> tb_emif_top.sv
// Purpose: Directed access sequences across all address-map modes
// Assumes: Index registers fixed at 8'h34 and 8'h56
// Notes: Busy length must equal the documented cycle sum
`timescale 1ns/1ps
module tb_emif_top
  import emif_pkg::*;
;
  logic clk, rst_n, cfg_we, tc_we, req, busy, done, int_en, int_we, ale, rd_n, wr_n, mux;
  logic [7:0] cfg_wd, tc_wd, page, idx0, idx1, rdata, int_wd, int_rd, cfg, tc, din, lat;
  logic ahi_oe, alo_oe, doe;
  logic [7:0] ahi, alo, dout;
  logic [12:0] int_addr;
  logic [15:0] dp;
  emif_req_s info;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  assign mux = !cfg[EMIF_CFG_MUX_BIT];
  // On-chip memory answers a pattern of its address
  assign int_rd = int_addr[7:0] ^ 8'h3c;
  emif_top emif_top_i (.i_clk_sys(clk), .i_rst_n(rst_n), .i_cfg_we(cfg_we),
    .i_cfg_wdata(cfg_wd), .i_tc_we(tc_we), .i_tc_wdata(tc_wd), .i_page(page),
    .i_idx_zero(idx0), .i_idx_one(idx1), .i_data_pointer(dp), .i_req(req),
    .i_req_info(info), .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_int_en(int_en),
    .o_int_we(int_we), .o_int_addr(int_addr), .o_int_wdata(int_wd), .i_int_rdata(int_rd),
    .o_cfg(cfg), .o_tc(tc), .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr_hi(ahi),
    .o_addr_hi_oe(ahi_oe), .o_addr_lo(alo), .o_addr_lo_oe(alo_oe), .o_data_out(dout),
    .o_data_oe(doe), .i_data_in(din));
  emif_sram_model emif_sram_model_i (.i_clk_sys(clk), .i_mux(mux), .i_ale(ale),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr_lo(alo), .i_data_out(dout), .o_data_in(din),
    .o_lat(lat));
  // Compare one value and count it
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One access: load config, request, watch pins until done
  task automatic run(input logic [7:0] c, input logic [7:0] t, input logic [7:0] pg,
    input logic [15:0] dpv, input logic [10:0] r, input logic off, input logic [15:0] a,
    input logic hi, input logic [7:0] rd);
    int n, k, e;
    logic ext, intr, hio, iwe, loe, dov;
    logic [15:0] sa, ia;
    logic [7:0] iwd, wd;
    n = 0;
    k = 0;
    ext = 1'b0;
    intr = 1'b0;
    hio = 1'b0;
    iwe = 1'b0;
    loe = 1'b0;
    dov = 1'b0;
    iwd = 8'h00;
    wd = 8'h00;
    sa = 16'h0000;
    ia = 16'h0000;
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_wd <= c;
    tc_we <= 1'b1;
    tc_wd <= t;
    @(posedge clk);
    cfg_we <= 1'b0;
    tc_we <= 1'b0;
    page <= pg;
    dp <= dpv;
    req <= 1'b1;
    info <= r;
    do begin
      @(posedge clk);
      req <= 1'b0;
      #1;
      k++;
      if (busy === 1'b1) n++;
      if (int_en === 1'b1) begin
        intr = 1'b1;
        ia = {3'h0, int_addr};
        iwe = int_we;
        iwd = int_wd;
      end
      if (rd_n === 1'b0 || wr_n === 1'b0) begin
        ext = 1'b1;
        hio = ahi_oe;
        loe = alo_oe;
        dov = doe;
        wd = dout;
        sa = {ahi_oe ? ahi : 8'h00, mux ? lat : alo};
      end
    end while (done !== 1'b1 && k < 60);
    e = 5 + t[7:6] + t[5:2] + t[1:0] + (c[4] ? 0 : 2 * (c[1:0] + 1));
    chk("done", 16'h0001, {15'h0, done});
    chk("cfg", {11'h000, c[4:0]}, {8'h00, cfg});
    chk("tc", {8'h00, t}, {8'h00, tc});
    chk("offchip", {15'h0, off}, {15'h0, ext});
    chk("onchip", {15'h0, !off}, {15'h0, intr});
    chk("addr", a, off ? sa : ia);
    chk("hi_oe", {15'h0, hi}, {15'h0, hio});
    chk("lo_oe", {15'h0, off && !mux}, {15'h0, loe});
    chk("d_oe", {15'h0, off && r[10]}, {15'h0, dov});
    if (off && r[10]) chk("wdata", {8'h00, r[7:0]}, {8'h00, wd});
    if (!off) chk("int_we", {15'h0, r[10]}, {15'h0, iwe});
    if (!off && r[10]) chk("int_wd", {8'h00, r[7:0]}, {8'h00, iwd});
    if (off) chk("busy_len", e[15:0], n[15:0]);
    if (!r[10]) chk("rdata", {8'h00, rd}, {8'h00, rdata});
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    {rst_n, cfg_we, tc_we, req, cfg_wd, tc_wd, page, dp} = '0;
    idx0 = 8'h34;
    idx1 = 8'h56;
    info = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("cfg_rst", {8'h00, EMIF_CFG_RESET}, {8'h00, cfg});
    chk("tc_rst", 16'h00ff, {8'h00, tc});
    run(8'h00, 8'h00, 8'h45, 16'h4321, 11'h000, 0, 16'h0534, 0, 8'h08);
    run(8'h00, 8'h00, 8'h45, 16'h4321, 11'h200, 0, 16'h0321, 0, 8'h1d);
    run(8'h14, 8'h00, 8'h45, 16'h0000, 11'h4a1, 1, 16'h0034, 0, 8'h00);
    run(8'h14, 8'h00, 8'h05, 16'h0000, 11'h000, 0, 16'h0534, 0, 8'h08);
    run(8'h14, 8'h00, 8'h05, 16'h0000, 11'h47e, 0, 16'h0534, 0, 8'h00);
    run(8'h14, 8'h96, 8'h05, 16'h1234, 11'h200, 0, 16'h1234, 0, 8'h08);
    run(8'h14, 8'h96, 8'h05, 16'h2034, 11'h200, 1, 16'h2034, 1, 8'ha1);
    run(8'h18, 8'h00, 8'h45, 16'h0000, 11'h5c3, 1, 16'h4556, 1, 8'h00);
    run(8'h1c, 8'h00, 8'h05, 16'h0000, 11'h100, 1, 16'h0056, 0, 8'hc3);
    run(8'h1c, 8'h00, 8'h05, 16'h0034, 11'h6b2, 1, 16'h0034, 1, 8'h00);
    run(8'h0c, 8'h00, 8'h00, 16'h4334, 11'h6e5, 1, 16'h4334, 1, 8'h00);
    run(8'hef, 8'hff, 8'h00, 16'h0000, 11'h000, 1, 16'h0034, 0, 8'he5);
    complete_run();
  end
endmodule
